// ===== design/swm_pkg.sv
/*
 * constants of the servo warning monitor: register byte addresses,
 * warning bit positions, reset values and timing counts.
 * assumes a 200 MHz pclk and a 16-bit apb address.
 */
package swm_pkg;

   // -----------------------------------------------------------------
   // clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int OVERLOAD_HOLD_US = 1000;
   localparam int OVERLOAD_HOLD_CYC = OVERLOAD_HOLD_US * CLK_MHZ;

   // -----------------------------------------------------------------
   // register byte addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_WARN_STATUS = 16'h2000;
   localparam logic [15:0] ADDR_CTRL = 16'h2004;
   localparam logic [15:0] ADDR_POS_LIMIT_HI = 16'h2008;
   localparam logic [15:0] ADDR_POS_LIMIT_LO = 16'h200C;
   localparam logic [15:0] ADDR_LOAD_RATE = 16'h2010;
   localparam logic [15:0] ADDR_WARNING_CHECK_MASK = 16'h2014;
   localparam logic [15:0] ADDR_SUPPLY_VOLT = 16'h2018;
   localparam logic [15:0] ADDR_IRQ_STATUS = 16'h201C;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h2020;
   localparam logic [15:0] ADDR_DISPLAY = 16'h2024;

   // -----------------------------------------------------------------
   // warning word bit positions
   // -----------------------------------------------------------------
   localparam int BIT_CELL_LOW = 1;
   localparam int BIT_TRAVEL = 2;
   localparam int BIT_LOAD = 4;
   localparam int BIT_COMBO = 5;
   localparam int BIT_SUPPLY = 6;
   localparam int BIT_EMERGENCY = 7;
   localparam int BIT_Z_PHASE = 14;

   localparam logic [15:0] WARN_BITS = 16'h00F6;
   localparam logic [15:0] MASK_BITS = 16'h40F6;
   localparam logic [15:0] MASK_RESET = 16'h40F6;

   // -----------------------------------------------------------------
   // control register fields and other register reset values
   // -----------------------------------------------------------------
   localparam int CTRL_ENC_INCREMENTAL = 0;
   localparam int CTRL_TRAVEL_EN = 1;
   localparam int CTRL_EMG_ASSIGNED = 2;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam logic [31:0] LIMIT_HI_RESET = 32'h7FFFFFFF;
   localparam logic [31:0] LIMIT_LO_RESET = 32'h80000000;
   localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

   // -----------------------------------------------------------------
   // thresholds and display letter
   // -----------------------------------------------------------------
   localparam logic [15:0] CELL_MIN_MV = 16'h0CE4;
   localparam logic [15:0] RATED_LOAD_PCT = 16'h0064;
   localparam logic [15:0] SUPPLY_MIN_MV = 16'h5DC0;
   localparam logic [7:0] DISPLAY_LETTER_W = 8'h57;

endpackage

// ===== design/swm_sync.sv
/*
 * two-flop synchroniser of a configurable width.
 * assumes a multi-bit input changes only slowly against pclk.
 */
module swm_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // -----------------------------------------------------------------
   // the first stage feeds the second only
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ===== design/swm_top.sv
/*
 * servo warning monitor: collects non-fatal warnings into a bit-coded
 * word, masks each check, clears warnings when causes vanish, shows
 * the code as W and two hex digits, and keeps the drive running unless the assigned emergency contact trips.
 * assumes an apb master on pclk; monitor pins are asynchronous.
 */
//
// Notes on behaviour
// - warnings flag only, servo keeps running except on the emergency warning
// - each warning clears itself when cause ends
// - per-bit check mask in mask register
// - bits: 1 battery, 2 travel, 4 overload
// - bits: 5 mismatch, 6 undervoltage, 7 emergency
// - mask bit 14 gates z-phase loss alarm
// - concurrent bits combine, shown W plus hex
// - battery low or missing raises battery warning
// - load above rated raises overload warning
// - assigned emergency contact stops and warns
// - motor current above drive current: mismatch
// - duplicate io function assignment: mismatch
// - incremental encoder use suppresses battery warning
// - supply below minimum raises undervoltage
// - battery replacement clears warning at once
module swm_top #(
   parameter int OVERLOAD_CYC = swm_pkg::OVERLOAD_HOLD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] cell_mv,
   input wire logic cell_present,
   input wire logic [15:0] load_pct,
   input wire logic [15:0] supply_mv,
   input wire logic emergency_stop_input,
   input wire logic z_phase_lost,
   input wire logic servo_on_command,
   input wire logic [15:0] motor_current_ma,
   input wire logic [15:0] drive_current_ma,
   input wire logic io_function_dup,
   input wire logic signed [31:0] cmd_position,
   output logic [15:0] warning_word,
   output logic warning_active,
   output logic [7:0] display_letter,
   output logic [7:0] display_code,
   output logic z_phase_loss_alarm,
   output logic emergency_stop,
   output logic servo_enable,
   output logic irq
);

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [15:0] cell_mv_s;
   logic cell_present_s;
   logic [15:0] load_pct_s;
   logic [15:0] supply_mv_s;
   logic emg_s;
   logic z_lost_s;
   logic servo_on_s;
   logic [15:0] motor_ma_s;
   logic [15:0] drive_ma_s;

   swm_sync #(.W(16)) u_sync_cell (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(cell_mv),
      .sync_out(cell_mv_s)
   );

   swm_sync #(.W(16)) u_sync_load (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(load_pct),
      .sync_out(load_pct_s)
   );

   swm_sync #(.W(16)) u_sync_supply (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(supply_mv),
      .sync_out(supply_mv_s)
   );

   swm_sync #(.W(16)) u_sync_motor (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(motor_current_ma),
      .sync_out(motor_ma_s)
   );

   swm_sync #(.W(16)) u_sync_drive (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(drive_current_ma),
      .sync_out(drive_ma_s)
   );

   swm_sync #(.W(4)) u_sync_bits (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({cell_present, emergency_stop_input, z_phase_lost,
                 servo_on_command}),
      .sync_out({cell_present_s, emg_s, z_lost_s, servo_on_s})
   );

   // -----------------------------------------------------------------
   // software state
   // -----------------------------------------------------------------
   logic [15:0] mask_q;
   logic [2:0] ctrl_q;
   logic signed [31:0] limit_hi_q;
   logic signed [31:0] limit_lo_q;
   logic [15:0] irq_mask_q;
   logic [15:0] irq_stat_q;

   logic setup;
   logic wr_en;
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= swm_pkg::MASK_RESET;
      end else if (wr_en && paddr == swm_pkg::ADDR_WARNING_CHECK_MASK) begin
         mask_q <= pwdata[15:0] & swm_pkg::MASK_BITS;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= swm_pkg::CTRL_RESET;
      end else if (wr_en && paddr == swm_pkg::ADDR_CTRL) begin
         ctrl_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_hi_q <= swm_pkg::LIMIT_HI_RESET;
         limit_lo_q <= swm_pkg::LIMIT_LO_RESET;
      end else if (wr_en && paddr == swm_pkg::ADDR_POS_LIMIT_HI) begin
         limit_hi_q <= pwdata;
      end else if (wr_en && paddr == swm_pkg::ADDR_POS_LIMIT_LO) begin
         limit_lo_q <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= swm_pkg::IRQ_MASK_RESET;
      end else if (wr_en && paddr == swm_pkg::ADDR_IRQ_MASK) begin
         irq_mask_q <= pwdata[15:0] & swm_pkg::WARN_BITS;
      end
   end

   // -----------------------------------------------------------------
   // warning causes
   // -----------------------------------------------------------------
   logic cell_low;
   logic travel_over;
   logic load_over;
   logic combo_bad;
   logic supply_low;
   logic emg_hit;
   logic [31:0] load_cnt_q;
   logic load_long;

   // a missing cell also counts as low; incremental use hides both
   assign cell_low = (!cell_present_s || cell_mv_s < swm_pkg::CELL_MIN_MV)
                     && !ctrl_q[swm_pkg::CTRL_ENC_INCREMENTAL];
   assign travel_over = ctrl_q[swm_pkg::CTRL_TRAVEL_EN]
                        && (cmd_position > limit_hi_q
                            || cmd_position < limit_lo_q);
   assign load_over = load_pct_s > swm_pkg::RATED_LOAD_PCT;
   assign combo_bad = (motor_ma_s > drive_ma_s)
                      || io_function_dup;
   assign supply_low = supply_mv_s < swm_pkg::SUPPLY_MIN_MV;
   assign emg_hit = emg_s && ctrl_q[swm_pkg::CTRL_EMG_ASSIGNED];

   // overload must persist, so short peaks pass without a warning
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_cnt_q <= 32'h00000000;
      end else if (!load_over) begin
         load_cnt_q <= 32'h00000000;
      end else if (!load_long) begin
         load_cnt_q <= load_cnt_q + 32'h00000001;
      end
   end

   assign load_long = load_cnt_q >= 32'(OVERLOAD_CYC);

   // -----------------------------------------------------------------
   // start-up hold
   // -----------------------------------------------------------------
   // synced pins read zero for two edges after reset, which looks like
   // a flat cell and a dead supply; the word is held off until then
   logic [1:0] warm_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm_q <= 2'h0;
      end else if (!warm_q[1]) begin
         warm_q <= warm_q + 2'h1;
      end
   end

   // -----------------------------------------------------------------
   // warning word
   // -----------------------------------------------------------------
   logic [15:0] raw_d;
   logic [15:0] warn_d;

   always_comb begin
      raw_d = 16'h0000;
      raw_d[swm_pkg::BIT_CELL_LOW] = cell_low;
      raw_d[swm_pkg::BIT_TRAVEL] = travel_over;
      raw_d[swm_pkg::BIT_LOAD] = load_long;
      raw_d[swm_pkg::BIT_COMBO] = combo_bad;
      raw_d[swm_pkg::BIT_SUPPLY] = supply_low;
      raw_d[swm_pkg::BIT_EMERGENCY] = emg_hit;
      warn_d = raw_d & mask_q & swm_pkg::WARN_BITS
               & {16{warm_q[1]}};
   end

   // no latching: a bit follows its cause and drops once it is gone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warning_word <= 16'h0000;
         warning_active <= 1'b0;
      end else begin
         warning_word <= warn_d;
         warning_active <= |warn_d;
      end
   end

   // -----------------------------------------------------------------
   // segment display
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display_letter <= 8'h00;
         display_code <= 8'h00;
      end else begin
         display_letter <= (|warn_d) ? swm_pkg::DISPLAY_LETTER_W : 8'h00;
         display_code <= warn_d[7:0];
      end
   end

   // -----------------------------------------------------------------
   // drive outputs
   // -----------------------------------------------------------------
   // warnings never reach the enable; only the emergency contact stops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         emergency_stop <= 1'b0;
         servo_enable <= 1'b0;
         z_phase_loss_alarm <= 1'b0;
      end else begin
         emergency_stop <= emg_hit;
         servo_enable <= servo_on_s && !emg_hit;
         z_phase_loss_alarm <= z_lost_s
                               && mask_q[swm_pkg::BIT_Z_PHASE];
      end
   end

   // -----------------------------------------------------------------
   // interrupts
   // -----------------------------------------------------------------
   logic [15:0] rise;
   logic [15:0] clr;

   assign rise = warn_d & ~warning_word;
   assign clr = (wr_en && paddr == swm_pkg::ADDR_IRQ_STATUS) ?
                pwdata[15:0] : 16'h0000;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 16'h0000;
      end else begin
         irq_stat_q <= (irq_stat_q & ~clr) | rise;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((((irq_stat_q & ~clr) | rise)) & irq_mask_q);
      end
   end

   // -----------------------------------------------------------------
   // apb read and answer
   // -----------------------------------------------------------------
   logic [31:0] rd_d;
   logic hit_d;

   always_comb begin
      rd_d = 32'h00000000;
      hit_d = 1'b1;
      unique case (paddr)
         swm_pkg::ADDR_WARN_STATUS: rd_d = {16'h0000, warning_word};
         swm_pkg::ADDR_CTRL: rd_d = {29'h00000000, ctrl_q};
         swm_pkg::ADDR_POS_LIMIT_HI: rd_d = limit_hi_q;
         swm_pkg::ADDR_POS_LIMIT_LO: rd_d = limit_lo_q;
         swm_pkg::ADDR_LOAD_RATE: rd_d = {16'h0000, load_pct_s};
         swm_pkg::ADDR_WARNING_CHECK_MASK: rd_d = {16'h0000, mask_q};
         swm_pkg::ADDR_SUPPLY_VOLT: rd_d = {16'h0000, supply_mv_s};
         swm_pkg::ADDR_IRQ_STATUS: rd_d = {16'h0000, irq_stat_q};
         swm_pkg::ADDR_IRQ_MASK: rd_d = {16'h0000, irq_mask_q};
         swm_pkg::ADDR_DISPLAY: rd_d = {16'h0000, display_letter,
                                        display_code};
         default: hit_d = 1'b0;
      endcase
   end

   // one wait-free access: answer is prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit_d;
         if (setup && !pwrite) begin
            prdata <= rd_d;
         end else if (!psel) begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

// ===== sim/swm_top_monitor.sv
/* port checker of the servo warning monitor, bound into swm_top.
   assumes synced pin causes reach the outputs three edges after they change, io_function_dup one edge. */
module swm_top_monitor #(
   parameter int OVERLOAD_CYC = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] cell_mv,
   input wire logic cell_present,
   input wire logic [15:0] load_pct,
   input wire logic [15:0] supply_mv,
   input wire logic emergency_stop_input,
   input wire logic z_phase_lost,
   input wire logic servo_on_command,
   input wire logic [15:0] motor_current_ma,
   input wire logic [15:0] drive_current_ma,
   input wire logic io_function_dup,
   input wire logic [15:0] warning_word,
   input wire logic warning_active,
   input wire logic [7:0] display_letter,
   input wire logic [7:0] display_code,
   input wire logic z_phase_loss_alarm,
   input wire logic emergency_stop,
   input wire logic servo_enable
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   int load_cnt_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // raw pin count, so it runs a little ahead of the synced one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) load_cnt_q <= 0;
      else load_cnt_q <= (load_pct > 16'h0064) ? load_cnt_q + 1 : 0;
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   word_bits_a: assert property (
      (warning_word & ~swm_pkg::WARN_BITS) == 16'h0000)
      else $error("unassigned warning bit set");
   shown_code_a: assert property (display_code == warning_word[7:0])
      else $error("display code differs from warning word");
   shown_letter_a: assert property (
      display_letter == (|warning_word ? 8'h57 : 8'h00))
      else $error("display letter wrong");
   active_flag_a: assert property (warning_active == |warning_word)
      else $error("warning active flag wrong");
   cell_clear_a: assert property (
      $past(cell_present, 3) && $past(cell_mv, 3) >= 16'h0CE4
      |-> !warning_word[1]) else $error("battery warning without cause");
   supply_clear_a: assert property (
      $past(supply_mv, 3) >= 16'h5DC0 |-> !warning_word[6])
      else $error("undervoltage warning without cause");
   combo_clear_a: assert property (
      !$past(io_function_dup) &&
      $past(motor_current_ma, 3) <= $past(drive_current_ma, 3)
      |-> !warning_word[5]) else $error("mismatch warning without cause");
   load_hold_a: assert property (
      $rose(warning_word[4]) |-> load_cnt_q >= OVERLOAD_CYC)
      else $error("overload warning too early");
   emg_stop_a: assert property (
      emergency_stop |-> !servo_enable && $past(emergency_stop_input, 3))
      else $error("emergency stop wrong");
   servo_run_a: assert property (
      $past(presetn, 4) &&
      $past(servo_on_command, 3) && $past(servo_on_command, 4) &&
      !$past(emergency_stop_input, 3) && !$past(emergency_stop_input, 4)
      |-> servo_enable) else $error("servo dropped by a warning");
   z_alarm_a: assert property (
      z_phase_loss_alarm |-> $past(z_phase_lost, 3))
      else $error("z-phase alarm without cause");
endmodule

bind swm_top swm_top_monitor #(.OVERLOAD_CYC(OVERLOAD_CYC)) u_mon (.*);

// ===== sim/swm_top_tb.sv
/* self-checking bench of the servo warning monitor over apb.
   assumes swm_pkg and the design are compiled before it. */
module swm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   localparam int OVC = 8;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = '0, cell_mv = 16'h0E10, load_pct = 16'h0032;
   logic [15:0] supply_mv = 16'hBB80, motor_current_ma = 16'h03E8;
   logic [15:0] drive_current_ma = 16'h07D0, warning_word;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, io_function_dup = 0, emergency_stop_input = 0;
   logic cell_present = 1, z_phase_lost = 0, servo_on_command = 1;
   logic signed [31:0] cmd_position = '0;
   logic warning_active, z_phase_loss_alarm, emergency_stop;
   logic servo_enable, irq;
   logic [7:0] display_letter, display_code;
   logic [33:0] exp_q[$];
   logic [7:0] bits[5] = '{8'h10, 8'h20, 8'h20, 8'h40, 8'h80};
   int fail_count = 0, n_tests = 0;
   always #2.5 pclk = ~pclk;
   swm_top #(.OVERLOAD_CYC(OVC)) dut (.*);
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (e !== g) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(logic w, logic [15:0] a, logic [31:0] d,
      logic [31:0] e, logic err);
      int n;
      n = 0;
      exp_q.push_back({w, err, e});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         finish_test();
      end
   endtask
   task automatic rd(logic [15:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask
   task automatic wr(logic [15:0] a, logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   // fixed wait: sync plus output flop plus the overload hold
   task automatic settle();
      repeat (OVC + 4) @(posedge pclk);
   endtask
   task automatic cause(int i, logic on);
      @(posedge pclk);
      case (i)
         0: load_pct <= on ? 16'(101 + $urandom % 200) : 16'($urandom % 101);
         1: motor_current_ma <= on ? 16'(2001 + $urandom % 900) : 16'h03E8;
         2: io_function_dup <= on;
         3: supply_mv <= on ? 16'($urandom % 24000) : 16'hBB80;
         default: emergency_stop_input <= on;
      endcase
   endtask
   // ---------------------------------------------------------------
   // scoreboard: oldest note against each completed transfer
   // ---------------------------------------------------------------
   always @(posedge pclk) begin : watch
      logic [33:0] e;
      if (psel && penable && pready && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
         if (!e[33]) cmp("prdata", e[31:0], prdata);
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      finish_test();
   end
   initial begin
      int s;
      s = $urandom(70);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(swm_pkg::ADDR_WARNING_CHECK_MASK, 32'h40F6);
      rd(swm_pkg::ADDR_CTRL, 32'h4);
      rd(swm_pkg::ADDR_POS_LIMIT_HI, 32'h7FFFFFFF);
      rd(swm_pkg::ADDR_WARN_STATUS, 32'h0);
      apb(1'b0, 16'h2028, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 16'h2028, '1, 32'h0, 1'b1);
      wr(swm_pkg::ADDR_WARNING_CHECK_MASK, '1);
      rd(swm_pkg::ADDR_WARNING_CHECK_MASK, 32'h40F6);
      wr(swm_pkg::ADDR_IRQ_MASK, 32'h6);
      wr(swm_pkg::ADDR_POS_LIMIT_HI, 32'h64);
      wr(swm_pkg::ADDR_CTRL, 32'h6);
      @(posedge pclk);
      cell_mv <= 16'h0CE3;
      cmd_position <= 32'sh65;
      settle();
      rd(swm_pkg::ADDR_WARN_STATUS, 32'h6);
      rd(swm_pkg::ADDR_DISPLAY, 32'h5706);
      cmp("servo_enable", 1, servo_enable);
      cmp("irq", 1, irq);
      wr(swm_pkg::ADDR_IRQ_STATUS, 32'h6);
      rd(swm_pkg::ADDR_IRQ_STATUS, 32'h0);
      cmp("irq", 0, irq);
      wr(swm_pkg::ADDR_WARNING_CHECK_MASK, 32'h40F2);
      rd(swm_pkg::ADDR_WARN_STATUS, 32'h2);
      @(posedge pclk);
      cell_mv <= 16'h0CE4;
      settle();
      rd(swm_pkg::ADDR_WARN_STATUS, 32'h0);
      cell_present <= 1'b0;
      settle();
      rd(swm_pkg::ADDR_WARN_STATUS, 32'h2);
      cmp("irq", 1, irq);
      wr(swm_pkg::ADDR_CTRL, 32'h7);
      settle();
      rd(swm_pkg::ADDR_WARN_STATUS, 32'h0);
      // the sticky battery event would otherwise hold irq high below
      wr(swm_pkg::ADDR_IRQ_STATUS, 32'h2);
      for (int i = 0; i < 5; i++) begin
         cause(i, 1'b1);
         settle();
         rd(swm_pkg::ADDR_WARN_STATUS, {24'h0, bits[i]});
         rd(swm_pkg::ADDR_DISPLAY, {16'h0, 8'h57, bits[i]});
         cmp("emergency_stop", i == 4, emergency_stop);
         cmp("servo_enable", i != 4, servo_enable);
         cmp("irq", 0, irq);
         cause(i, 1'b0);
         settle();
         rd(swm_pkg::ADDR_WARN_STATUS, 32'h0);
      end
      z_phase_lost <= 1'b1;
      settle();
      cmp("z_alarm", 1, z_phase_loss_alarm);
      wr(swm_pkg::ADDR_WARNING_CHECK_MASK, 32'h00F2);
      settle();
      cmp("z_alarm", 0, z_phase_loss_alarm);
      finish_test();
   end
endmodule
